// ==== giopfs_pkg.sv ====
// package: register map, field positions, reset values and pin carriers
package giopfs_pkg;

	// ************************************************************
	// register map (byte addresses, one word each, not word aligned)
	// ************************************************************
	localparam logic [7:0] ADDR_IO_LINE_DATA_MASK   = 8'h56;
	localparam logic [7:0] ADDR_IO_LINE_DIRECTION   = 8'h57;
	localparam logic [7:0] ADDR_PIN_ROLE_SELECT     = 8'h66;
	localparam logic [7:0] ADDR_FEATURE_CONTROL_ONE = 8'hA0;
	localparam logic [7:0] ADDR_ROLE_INPUT_STATUS   = 8'hB0;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int ROLE_STOP_GRANT_BIT  = 3;
	localparam int ROLE_CPU_SPEED_BIT   = 2;
	localparam int ROLE_ZERO_WAIT_BIT   = 1;
	localparam int FEAT_LOCAL_BUS_BIT   = 5;
	localparam int FEAT_ISA_CLOCK_BIT   = 4;
	localparam int MASK_FIELD_LSB       = 4;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [3:0] RST_IO_DATA      = 4'h0;
	localparam logic [3:0] RST_IO_DIRECTION = 4'h0;
	localparam logic [7:0] RST_PIN_ROLE     = 8'h00;
	localparam logic [7:0] RST_FEATURE_ONE  = 8'h00;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic [3:0] data;
		logic [3:0] oe;
		logic       dma_ack_two;
		logic       dma_ack_two_oe;
	} giopfs_pin_out_s;

	typedef struct packed {
		logic stop_grant_ack_in;
		logic zero_wait_req_in;
		logic isa_clock_in;
		logic local_bus_request_in;
	} giopfs_role_in_s;

	typedef struct packed {
		logic [7:0] io_data_mask;
		logic [7:0] io_direction;
		logic [7:0] pin_role;
		logic [7:0] feature_one;
	} giopfs_cfg_s;

	function automatic logic [3:0] giopfs_masked(input logic [3:0] old_v, input logic [7:0] wr);
		giopfs_masked = (old_v & ~wr[7:4]) | (wr[3:0] & wr[7:4]);
	endfunction

endpackage

// ==== giopfs_wb_slave.sv ====
// classic wishbone slave front end: address pass-through, one-cycle ack, write strobe
`timescale 1ns/1ns
module giopfs_wb_slave (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        cyc,
	input  wire logic        stb,
	input  wire logic        we,
	input  wire logic [3:0]  sel,
	input  wire logic [7:0]  adr,
	output logic             ack_r,
	output logic             wr_stb,
	output logic [7:0]       wr_adr
);
	import giopfs_pkg::*;

	// ************************************************************
	// ack generation
	// ************************************************************
	logic ack_nxt;

	// ack drops the cycle after it was given, so one beat per request
	always_comb begin
		ack_nxt = cyc & stb & ~ack_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else if (ce) begin
			ack_r <= ack_nxt;
		end
	end

	// write takes effect on the edge at which ack is high; only lane 0 holds data
	assign wr_stb = ce & cyc & stb & we & ack_r & sel[0];
	assign wr_adr = adr;
endmodule

// ==== giopfs_pin_mux.sv ====
// pin role multiplexer: decides what each line drives and what it carries in
`timescale 1ns/1ns
module giopfs_pin_mux (
	input  giopfs_pkg::giopfs_cfg_s      cfg,
	input  wire logic [3:0]              io_out,
	input  wire logic [3:0]              pin_in,
	input  wire logic                    cpu_full_speed,
	input  wire logic                    local_bus_grant,
	input  wire logic                    dma_ack_two_in,
	output giopfs_pkg::giopfs_pin_out_s  pins,
	output giopfs_pkg::giopfs_role_in_s  roles
);
	import giopfs_pkg::*;

	logic isa_clk_sel;
	logic speed_sel;
	logic lbus_sel;

	always_comb begin
		isa_clk_sel = cfg.feature_one[FEAT_ISA_CLOCK_BIT];
		speed_sel   = cfg.pin_role[ROLE_CPU_SPEED_BIT] & ~isa_clk_sel;
		lbus_sel    = cfg.feature_one[FEAT_LOCAL_BUS_BIT];
		pins.data   = io_out;
		pins.oe     = cfg.io_direction[3:0];
		// line 3: stop grant ack is an input, never driven by us
		if (cfg.pin_role[ROLE_STOP_GRANT_BIT]) begin
			pins.oe[3] = 1'b0;
		end
		// line 2: clock input wins over speed output
		if (isa_clk_sel) begin
			pins.oe[2] = 1'b0;
		end else if (speed_sel) begin
			pins.oe[2]   = 1'b1;
			pins.data[2] = cpu_full_speed;
		end
		if (cfg.pin_role[ROLE_ZERO_WAIT_BIT]) begin
			pins.oe[1] = 1'b0;
		end
		// local bus pair: line 0 request in, dma ack pin becomes grant out
		if (lbus_sel) begin
			pins.oe[0]          = 1'b0;
			pins.dma_ack_two    = local_bus_grant;
		end else begin
			pins.dma_ack_two    = dma_ack_two_in;
		end
		pins.dma_ack_two_oe = 1'b1;
		roles.stop_grant_ack_in    = cfg.pin_role[ROLE_STOP_GRANT_BIT] & pin_in[3];
		roles.isa_clock_in         = isa_clk_sel & pin_in[2];
		roles.zero_wait_req_in     = cfg.pin_role[ROLE_ZERO_WAIT_BIT] & pin_in[1];
		roles.local_bus_request_in = lbus_sel & pin_in[0];
	end
endmodule

// ==== giopfs_top.sv ====
// general io line block with pin function select, classic wishbone registers
//
// Overview of operation
// - write updates only data bits with mask set
// - data read returns live pin levels
// - data driven only where direction bit is one, except line 2 in speed role
// - direction bits 3:0, one means output
// - role bit 3 makes line 3 stop-grant input
// - role bit 2 makes line 2 speed output unless feature bit 4 is set
// - role bit 1 makes line 1 zero-wait input
// - feature bit 5 gives local bus request/grant
// - feature bit 4 makes line 2 clock input
`timescale 1ns/1ns
module giopfs_top (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic [3:0]  GENERAL_IO_LINES_I,
	output logic [3:0]       GENERAL_IO_LINES_O,
	output logic [3:0]       GENERAL_IO_LINES_OE,
	input  wire logic        CPU_FULL_SPEED,
	input  wire logic        LOCAL_BUS_GRANT,
	input  wire logic        DMA_ACK_TWO_IN,
	output logic             DMA_ACK_TWO_O,
	output logic             DMA_ACK_TWO_OE,
	output logic             STOP_GRANT_ACK_IN,
	output logic             ZERO_WAIT_REQ_IN,
	output logic             ISA_CLOCK_IN,
	output logic             LOCAL_BUS_REQUEST_IN
);
	import giopfs_pkg::*;

	// ************************************************************
	// bus front end
	// ************************************************************
	logic       wr_stb;
	logic [7:0] wr_adr;
	logic       ack_r;

	giopfs_wb_slave u_wb (
		.clk    (MCLK),
		.rst    (RST),
		.ce     (CE),
		.cyc    (WB_CYC_I),
		.stb    (WB_STB_I),
		.we     (WB_WE_I),
		.sel    (WB_SEL_I),
		.adr    (WB_ADR_I),
		.ack_r  (ack_r),
		.wr_stb (wr_stb),
		.wr_adr (wr_adr)
	);
	assign WB_ACK_O = ack_r;

	// ************************************************************
	// address decode
	// ************************************************************
	// one decode feeds both the write and the read path, so the two maps cannot drift apart
	typedef enum {
		REG_DATA_MASK,
		REG_DIRECTION,
		REG_PIN_ROLE,
		REG_FEATURE_ONE,
		REG_ROLE_STATUS,
		REG_NONE
	} giopfs_reg_e;

	// the status word decodes on its own so a write to it falls through and drops
	function automatic giopfs_reg_e giopfs_decode(input logic [7:0] adr);
		unique case (adr)
			ADDR_IO_LINE_DATA_MASK: begin
				giopfs_decode = REG_DATA_MASK;
			end
			ADDR_IO_LINE_DIRECTION: begin
				giopfs_decode = REG_DIRECTION;
			end
			ADDR_PIN_ROLE_SELECT: begin
				giopfs_decode = REG_PIN_ROLE;
			end
			ADDR_FEATURE_CONTROL_ONE: begin
				giopfs_decode = REG_FEATURE_ONE;
			end
			ADDR_ROLE_INPUT_STATUS: begin
				giopfs_decode = REG_ROLE_STATUS;
			end
			default: begin
				giopfs_decode = REG_NONE;
			end
		endcase
	endfunction

	giopfs_reg_e wr_sel;
	giopfs_reg_e rd_sel;

	always_comb begin
		wr_sel = giopfs_decode(wr_adr);
		rd_sel = giopfs_decode(WB_ADR_I);
	end

	// ************************************************************
	// configuration registers
	// ************************************************************
	// writes to unmapped or read-only words are acknowledged and dropped
	logic [3:0] io_data_r;
	logic [3:0] io_data_nxt;
	logic [3:0] io_dir_r;
	logic [3:0] io_dir_nxt;
	logic [7:0] pin_role_r;
	logic [7:0] pin_role_nxt;
	logic [7:0] feature_one_r;
	logic [7:0] feature_one_nxt;

	// data bits: only lanes whose mask bit is set in the same write move
	always_comb begin
		io_data_nxt = io_data_r;
		if (wr_stb && wr_sel == REG_DATA_MASK) begin
			io_data_nxt = giopfs_masked(io_data_r, WB_DAT_I[7:0]);
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			io_data_r <= RST_IO_DATA;
		end else if (CE) begin
			io_data_r <= io_data_nxt;
		end
	end

	// direction bits; line roles override them in the mux, not here
	always_comb begin
		io_dir_nxt = io_dir_r;
		if (wr_stb && wr_sel == REG_DIRECTION) begin
			io_dir_nxt = WB_DAT_I[3:0];
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			io_dir_r <= RST_IO_DIRECTION;
		end else if (CE) begin
			io_dir_r <= io_dir_nxt;
		end
	end

	// pin role select
	always_comb begin
		pin_role_nxt = pin_role_r;
		if (wr_stb && wr_sel == REG_PIN_ROLE) begin
			pin_role_nxt = WB_DAT_I[7:0];
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pin_role_r <= RST_PIN_ROLE;
		end else if (CE) begin
			pin_role_r <= pin_role_nxt;
		end
	end

	// feature control; bits beyond the two line roles are only stored and read back
	always_comb begin
		feature_one_nxt = feature_one_r;
		if (wr_stb && wr_sel == REG_FEATURE_ONE) begin
			feature_one_nxt = WB_DAT_I[7:0];
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			feature_one_r <= RST_FEATURE_ONE;
		end else if (CE) begin
			feature_one_r <= feature_one_nxt;
		end
	end

	// ************************************************************
	// pin role multiplexing
	// ************************************************************
	giopfs_cfg_s      cfg;
	giopfs_pin_out_s  pins_c;
	giopfs_role_in_s  roles_c;

	// direction is the plain bit; software must clear it for stop-grant use
	// but the mux also forces line 3 off so a slip cannot fight the cpu
	always_comb begin
		cfg.io_data_mask = {4'h0, io_data_r};
		cfg.io_direction = {4'h0, io_dir_r};
		cfg.pin_role     = pin_role_r;
		cfg.feature_one  = feature_one_r;
	end

	giopfs_pin_mux u_mux (
		.cfg             (cfg),
		.io_out          (io_data_r),
		.pin_in          (GENERAL_IO_LINES_I),
		.cpu_full_speed  (CPU_FULL_SPEED),
		.local_bus_grant (LOCAL_BUS_GRANT),
		.dma_ack_two_in  (DMA_ACK_TWO_IN),
		.pins            (pins_c),
		.roles           (roles_c)
	);

	// ************************************************************
	// registered pin and role outputs
	// ************************************************************
	// one cycle of latency on every pin keeps outputs glitch free
	giopfs_pin_out_s pins_r;
	giopfs_pin_out_s pins_nxt;

	always_comb begin
		pins_nxt = pins_c;
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pins_r <= '0;
		end else if (CE) begin
			pins_r <= pins_nxt;
		end
	end

	// role levels are sampled once here, so software and the role logic see the same value
	giopfs_role_in_s roles_r;
	giopfs_role_in_s roles_nxt;

	always_comb begin
		roles_nxt = roles_c;
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			roles_r <= '0;
		end else if (CE) begin
			roles_r <= roles_nxt;
		end
	end

	assign GENERAL_IO_LINES_O   = pins_r.data;
	assign GENERAL_IO_LINES_OE  = pins_r.oe;
	assign DMA_ACK_TWO_O        = pins_r.dma_ack_two;
	assign DMA_ACK_TWO_OE       = pins_r.dma_ack_two_oe;
	assign STOP_GRANT_ACK_IN    = roles_r.stop_grant_ack_in;
	assign ZERO_WAIT_REQ_IN     = roles_r.zero_wait_req_in;
	assign ISA_CLOCK_IN         = roles_r.isa_clock_in;
	assign LOCAL_BUS_REQUEST_IN = roles_r.local_bus_request_in;

	// ************************************************************
	// read data
	// ************************************************************
	logic [31:0] rd_r;
	logic [31:0] rd_nxt;

	// read data is captured on the request edge so it is valid with ack
	// line data reads the pins themselves, so a line held by the far side reads as it stands
	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (rd_sel)
			REG_DATA_MASK: begin
				rd_nxt[3:0] = GENERAL_IO_LINES_I;
			end
			REG_DIRECTION: begin
				rd_nxt[3:0] = io_dir_r;
			end
			REG_PIN_ROLE: begin
				rd_nxt[7:0] = pin_role_r;
			end
			REG_FEATURE_ONE: begin
				rd_nxt[7:0] = feature_one_r;
			end
			REG_ROLE_STATUS: begin
				rd_nxt[3:0] = {roles_r.stop_grant_ack_in, roles_r.isa_clock_in,
					roles_r.zero_wait_req_in, roles_r.local_bus_request_in};
			end
			REG_NONE: begin
				rd_nxt = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rd_r <= 32'h0000_0000;
		end else if (CE) begin
			rd_r <= rd_nxt;
		end
	end

	assign WB_DAT_O = rd_r;
endmodule

// ==== giopfs_props.sv ====
// checker: register and pin role behaviour seen at the block ports
`timescale 1ns/1ns
module giopfs_props (
	input wire logic        MCLK,
	input wire logic        RST,
	input wire logic        WB_ACK_O,
	input wire logic        WB_WE_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic [3:0]  GENERAL_IO_LINES_I,
	input wire logic [3:0]  GENERAL_IO_LINES_O,
	input wire logic [3:0]  GENERAL_IO_LINES_OE,
	input wire logic        CPU_FULL_SPEED,
	input wire logic        LOCAL_BUS_GRANT,
	input wire logic        DMA_ACK_TWO_IN,
	input wire logic        DMA_ACK_TWO_O,
	input wire logic        STOP_GRANT_ACK_IN,
	input wire logic        ZERO_WAIT_REQ_IN,
	input wire logic        ISA_CLOCK_IN,
	input wire logic        LOCAL_BUS_REQUEST_IN
);
	import giopfs_pkg::*;
	// ****************************************
	// shadow of the registers, built from acked writes
	// ****************************************
	logic [3:0] dat_r, dir_r, dat_nxt, dir_nxt, plain, oe_exp;
	logic [7:0] role_r, feat_r, role_nxt, feat_nxt;
	logic       wr;
	always_comb begin
		wr = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
		dat_nxt = dat_r;
		dir_nxt = dir_r;
		role_nxt = role_r;
		feat_nxt = feat_r;
		if (wr && WB_ADR_I == ADDR_IO_LINE_DATA_MASK)
			dat_nxt = (dat_r & ~WB_DAT_I[7:4]) | (WB_DAT_I[3:0] & WB_DAT_I[7:4]);
		if (wr && WB_ADR_I == ADDR_IO_LINE_DIRECTION)
			dir_nxt = WB_DAT_I[3:0];
		if (wr && WB_ADR_I == ADDR_PIN_ROLE_SELECT)
			role_nxt = WB_DAT_I[7:0];
		if (wr && WB_ADR_I == ADDR_FEATURE_CONTROL_ONE)
			feat_nxt = WB_DAT_I[7:0];
		plain = dir_r & {~role_r[3], ~(role_r[2] | feat_r[4]), ~role_r[1], ~feat_r[5]};
		oe_exp = plain | {1'b0, role_r[2] & ~feat_r[4], 2'h0};
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			{dat_r, dir_r, role_r, feat_r} <= 24'h0;
		else
			{dat_r, dir_r, role_r, feat_r} <= {dat_nxt, dir_nxt, role_nxt, feat_nxt};
	end
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	a_read_live:
		assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == ADDR_IO_LINE_DATA_MASK
			|-> WB_DAT_O[3:0] == $past(GENERAL_IO_LINES_I)) else $error("data read not live pin level");
	a_masked_data:
		assert property ((GENERAL_IO_LINES_O & $past(plain)) == ($past(dat_r) & $past(plain)))
			else $error("driven data not the masked write value");
	a_line_enable:
		assert property (GENERAL_IO_LINES_OE == $past(oe_exp)) else $error("line enables wrong");
	a_stop_grant:
		assert property ($past(role_r[3]) |-> !GENERAL_IO_LINES_OE[3]
			&& STOP_GRANT_ACK_IN == $past(GENERAL_IO_LINES_I[3])) else $error("stop grant role wrong");
	a_speed_out:
		assert property ($past(role_r[2] && !feat_r[4]) |-> GENERAL_IO_LINES_OE[2]
			&& GENERAL_IO_LINES_O[2] == $past(CPU_FULL_SPEED)) else $error("speed output wrong");
	a_zero_wait:
		assert property ($past(role_r[1]) |-> !GENERAL_IO_LINES_OE[1]
			&& ZERO_WAIT_REQ_IN == $past(GENERAL_IO_LINES_I[1])) else $error("zero wait role wrong");
	a_local_bus:
		assert property ($past(feat_r[5]) |-> !GENERAL_IO_LINES_OE[0] && DMA_ACK_TWO_O == $past(LOCAL_BUS_GRANT)
			&& LOCAL_BUS_REQUEST_IN == $past(GENERAL_IO_LINES_I[0])) else $error("local bus role wrong");
	a_dma_plain:
		assert property (!$past(RST) && !$past(feat_r[5]) |-> DMA_ACK_TWO_O == $past(DMA_ACK_TWO_IN))
			else $error("dma ack pin wrong");
	a_isa_clock:
		assert property ($past(feat_r[4]) |-> !GENERAL_IO_LINES_OE[2]
			&& ISA_CLOCK_IN == $past(GENERAL_IO_LINES_I[2])) else $error("clock input role wrong");
endmodule
bind giopfs_top giopfs_props u_giopfs_props (.*);

// ==== giopfs_board.sv ====
// partner: board side of the four lines, pull-ups on undriven lines
`timescale 1ns/1ns
module giopfs_board (
	input  wire logic [3:0] drv_o,
	input  wire logic [3:0] drv_oe,
	input  wire logic [3:0] ext_val,
	input  wire logic [3:0] ext_en,
	output logic [3:0]      level
);
	// pull-up keeps a released line high instead of leaving the old value
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			level[i] = drv_oe[i] ? drv_o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule

// ==== test_general_io_pin_function_select.sv ====
// testbench: masked writes, live reads and pin roles over wishbone
`timescale 1ns/1ns
module test_general_io_pin_function_select;
	import giopfs_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  sel = 4'h0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, q;
	logic [3:0]  lvl, pin_o, pin_oe;
	logic [3:0]  ext_val = 4'h0;
	logic [3:0]  ext_en = 4'h0;
	logic        spd = 1'b0;
	logic        gnt = 1'b0;
	logic        dma_in = 1'b0;
	logic        ack, dma_o, dma_oe, sg, zw, ic, lr;
	int          err_count = 0;
	int          checks = 0;
	always #2 mclk = ~mclk;
	giopfs_top u_giopfs_top (.MCLK(mclk), .RST(rst), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.GENERAL_IO_LINES_I(lvl), .GENERAL_IO_LINES_O(pin_o), .GENERAL_IO_LINES_OE(pin_oe),
		.CPU_FULL_SPEED(spd), .LOCAL_BUS_GRANT(gnt), .DMA_ACK_TWO_IN(dma_in), .DMA_ACK_TWO_O(dma_o),
		.DMA_ACK_TWO_OE(dma_oe), .STOP_GRANT_ACK_IN(sg), .ZERO_WAIT_REQ_IN(zw), .ISA_CLOCK_IN(ic),
		.LOCAL_BUS_REQUEST_IN(lr));
	giopfs_board u_giopfs_board (.drv_o(pin_o), .drv_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en), .level(lvl));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic complete_run;
		$display("mismatches %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	// the slave answers when it will; ack or the 16-cycle bound ends the wait
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		{cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, 24'h0, d, s};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		q = rdat;
		{cyc, stb, we} <= 3'h0;
		if (ack !== 1'b1) begin
			err_count++;
			complete_run();
		end
	endtask
	task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00, 4'hF);
		chk(name, {24'h0, exp}, q);
	endtask
	task automatic settle;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_vals;
		rd("role reset", ADDR_PIN_ROLE_SELECT, 8'h00);
		rd("feature reset", ADDR_FEATURE_CONTROL_ONE, 8'h00);
		rd("direction reset", ADDR_IO_LINE_DIRECTION, 8'h00);
		chk("dma enable", 32'h1, {31'h0, dma_oe});
		wb(1'b1, 8'h10, 8'hFF, 4'h1);
		rd("unmapped", 8'h10, 8'h00);
	endtask
	task automatic t_mask;
		wb(1'b1, ADDR_IO_LINE_DIRECTION, 8'h0F, 4'h1);
		wb(1'b1, ADDR_IO_LINE_DATA_MASK, 8'hFF, 4'h1);
		wb(1'b1, ADDR_IO_LINE_DATA_MASK, 8'h50, 4'h1);
		wb(1'b1, ADDR_IO_LINE_DATA_MASK, 8'hF0, 4'h2);
		settle();
		chk("enables", 32'hF, {28'h0, pin_oe});
		chk("data out", 32'hA, {28'h0, pin_o});
		rd("direction", ADDR_IO_LINE_DIRECTION, 8'h0F);
		rd("driven level", ADDR_IO_LINE_DATA_MASK, 8'h0A);
		wb(1'b1, ADDR_IO_LINE_DIRECTION, 8'h00, 4'h1);
		{ext_en, ext_val} <= 8'hF5;
		settle();
		chk("inputs", 32'h0, {28'h0, pin_oe});
		rd("live level", ADDR_IO_LINE_DATA_MASK, 8'h05);
	endtask
	task automatic t_roles;
		wb(1'b1, ADDR_IO_LINE_DIRECTION, 8'h07, 4'h1);
		wb(1'b1, ADDR_PIN_ROLE_SELECT, 8'h0E, 4'h1);
		{ext_val, spd} <= 5'h15;
		settle();
		chk("role enables", 32'h5, {28'h0, pin_oe});
		chk("speed out", 32'h1, {31'h0, pin_o[2]});
		chk("role inputs", 32'h3, {30'h0, sg, zw});
		wb(1'b1, ADDR_FEATURE_CONTROL_ONE, 8'h30, 4'h1);
		{ext_val, gnt} <= 5'h1F;
		settle();
		chk("clock wins", 32'h0, {28'h0, pin_oe});
		chk("bus roles", 32'h7, {29'h0, ic, lr, dma_o});
		rd("role status", ADDR_ROLE_INPUT_STATUS, 8'h0F);
		{gnt, dma_in} <= 2'h1;
		settle();
		chk("grant low", 32'h0, {31'h0, dma_o});
		wb(1'b1, ADDR_FEATURE_CONTROL_ONE, 8'h00, 4'h1);
		settle();
		chk("dma plain", 32'h2, {30'h0, dma_o, lr});
	endtask
	task automatic t_mid_reset;
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd("role after reset", ADDR_PIN_ROLE_SELECT, 8'h00);
		rd("direction after reset", ADDR_IO_LINE_DIRECTION, 8'h00);
		settle();
		chk("enables after reset", 32'h0, {28'h0, pin_oe});
		chk("dma enable after reset", 32'h1, {31'h0, dma_oe});
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_reset_vals();
		t_mask();
		t_roles();
		t_mid_reset();
		complete_run();
	end
endmodule
